// *** logic/dpcp_defs.vh ***
// constants shared by the configuration port and its eeprom loader
`ifndef DPCP_DEFS_VH
`define DPCP_DEFS_VH

// timing
`define DPCP_CLK_HZ     20000000
`define DPCP_SCL_HZ     100000
`define DPCP_QTR_CYC    (`DPCP_CLK_HZ / (`DPCP_SCL_HZ * 4))
`define DPCP_QTR_W      6
`define DPCP_BOOT_WAIT  4'hf

// register file
`define DPCP_NREG       16
`define DPCP_RA_W       4
`define DPCP_REG_RST    8'h00
`define DPCP_IRQ_FIRST  4'hc

// two-wire addressing
`define DPCP_SLV_BASE   5'h0c
`define DPCP_EE_ADDR    7'h50
`define DPCP_EE_START   8'h00
`define DPCP_RD_BIT     1'b1
`define DPCP_WR_BIT     1'b0
`define DPCP_FIRST_DATA 5'h03
`define DPCP_LAST_DATA  5'h12

// synchroniser bit positions
`define DPCP_P_SDA      0
`define DPCP_P_SCL      1
`define DPCP_P_DIN      2
`define DPCP_P_SEL      3
`define DPCP_P_MODE     4
`define DPCP_P_WP       5

`endif

// *** logic/dpcp_eeprom_loader.v ***
// two-wire master that copies the register image out of an external eeprom
`timescale 1ns/1ns
`include "dpcp_defs.vh"

module dpcp_eeprom_loader (
    input  wire                  clk,
    input  wire                  rstn,
    input  wire                  start,
    input  wire                  sda_in,
    output reg                   scl_oe_n,
    output reg                   sda_oe_n,
    output reg                   busy,
    output reg                   done,
    output reg                   error,
    output reg                   wr_en,
    output reg  [`DPCP_RA_W-1:0] wr_addr,
    output reg  [7:0]            wr_data
);
    localparam S_IDLE  = 5'h01;
    localparam S_START = 5'h02;
    localparam S_BIT   = 5'h04;
    localparam S_STOP  = 5'h08;
    localparam S_END   = 5'h10;
    localparam integer           QTR_FULL = `DPCP_QTR_CYC - 1;
    localparam [`DPCP_QTR_W-1:0] QTR_LAST = QTR_FULL[`DPCP_QTR_W-1:0];

    reg [4:0]             state;
    reg [`DPCP_QTR_W-1:0] qcnt;
    reg [1:0]             ph;
    reg [3:0]             bitn;
    reg [4:0]             step;
    reg [7:0]             shreg;

    wire tick    = busy && (qcnt == QTR_LAST);
    wire reading = (step >= `DPCP_FIRST_DATA);
    wire last    = (step == `DPCP_LAST_DATA);
    wire [4:0] data_idx = step - `DPCP_FIRST_DATA;

    // byte sent for each step of the load sequence
    function [7:0] tx_byte;
        input [4:0] s;
        begin
            case (s)
                5'h00:   tx_byte = {`DPCP_EE_ADDR, `DPCP_WR_BIT};
                5'h01:   tx_byte = `DPCP_EE_START;
                5'h02:   tx_byte = {`DPCP_EE_ADDR, `DPCP_RD_BIT};
                default: tx_byte = 8'hff;
            endcase
        end
    endfunction

    // quarter bit divider
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            qcnt <= {`DPCP_QTR_W{1'b0}};
        else if (!busy || tick)
            qcnt <= {`DPCP_QTR_W{1'b0}};
        else
            qcnt <= qcnt + 1'b1;
    end

    // start, byte, ack and stop sequencing
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state    <= S_IDLE;
            ph       <= 2'h0;
            bitn     <= 4'h0;
            step     <= 5'h00;
            shreg    <= 8'hff;
            scl_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
            busy     <= 1'b0;
            done     <= 1'b0;
            error    <= 1'b0;
            wr_en    <= 1'b0;
            wr_addr  <= {`DPCP_RA_W{1'b0}};
            wr_data  <= 8'h00;
        end
        else
        begin
            wr_en <= 1'b0;
            if (state == S_IDLE)
            begin
                if (start)
                begin
                    state <= S_START;
                    busy  <= 1'b1;
                    ph    <= 2'h0;
                    step  <= 5'h00;
                end
            end
            else if (tick)
            begin
                ph <= ph + 1'b1;
                case (state)
                    S_START:
                        case (ph)
                            2'h0: sda_oe_n <= 1'b1;
                            2'h1: scl_oe_n <= 1'b1;
                            2'h2: sda_oe_n <= 1'b0;
                            default:
                            begin
                                scl_oe_n <= 1'b0;
                                state    <= S_BIT;
                                bitn     <= 4'h0;
                                shreg    <= tx_byte(step);
                            end
                        endcase
                    S_BIT:
                        case (ph)
                            2'h0:
                                if (bitn[3])
                                    sda_oe_n <= !(reading && !last); // ack every read byte but the last
                                else
                                    sda_oe_n <= reading | shreg[7];
                            2'h1: scl_oe_n <= 1'b1;
                            2'h2:
                                if (!bitn[3])
                                    shreg <= {shreg[6:0], sda_in};
                                else if (!reading && sda_in)
                                    error <= 1'b1;           // eeprom did not answer
                            default:
                            begin
                                scl_oe_n <= 1'b0;
                                if (!bitn[3])
                                    bitn <= bitn + 1'b1;
                                else
                                begin
                                    bitn <= 4'h0;
                                    if (reading)
                                    begin
                                        wr_en   <= 1'b1;
                                        wr_addr <= data_idx[`DPCP_RA_W-1:0];
                                        wr_data <= shreg;
                                    end
                                    if (error || last)
                                        state <= S_STOP;
                                    else if (step == 5'h01)
                                    begin
                                        step  <= step + 1'b1;
                                        state <= S_START;       // repeated start for the read
                                    end
                                    else
                                    begin
                                        step  <= step + 1'b1;
                                        shreg <= tx_byte(step + 1'b1);
                                    end
                                end
                            end
                        endcase
                    S_STOP:
                        case (ph)
                            2'h0: sda_oe_n <= 1'b0;
                            2'h1: scl_oe_n <= 1'b1;
                            2'h2: sda_oe_n <= 1'b1;
                            default: state <= S_END;
                        endcase
                    default:
                    begin
                        state <= S_IDLE;
                        busy  <= 1'b0;
                        done  <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule

// *** logic/dpcp_config_port.v ***
// dual protocol register programming port with eeprom boot load
`timescale 1ns/1ns
`include "dpcp_defs.vh"

// Behaviour
// - select low two-wire slave, high four-wire
// - low shared pin: address bit or select
// - second shared pin: address bit or data
// - data pin: two-wire data or read out
// - clock pin: two-wire clock or input only
// - master loads registers from external eeprom
// - no eeprom load in four-wire mode
// - protected writes change only interrupt registers
// - reset returns registers and machines to defaults
module dpcp_config_port (
    input  wire                  clk,
    input  wire                  rstn,
    input  wire                  port_protocol_select,
    input  wire                  shared_sel_pin,
    input  wire                  shared_din_pin,
    input  wire                  write_protect_n,
    input  wire                  serial_clock_line_in,
    output reg                   serial_clock_line_out,
    output reg                   serial_clock_line_oe_n,
    input  wire                  twowire_data_line_in,
    output reg                   twowire_data_line_out,
    output reg                   twowire_data_line_oe_n,
    input  wire [`DPCP_RA_W-1:0] cfg_rd_addr,
    output reg  [7:0]            cfg_rd_data,
    output reg                   spi_mode_active,
    output reg                   load_busy,
    output reg                   load_done,
    output reg                   load_error
);
    localparam SL_IDLE = 5'h01;
    localparam SL_RX   = 5'h02;
    localparam SL_ACK  = 5'h04;
    localparam SL_TX   = 5'h08;
    localparam SL_MACK = 5'h10;

    reg  [7:0]            regs [0:`DPCP_NREG-1];
    reg  [5:0]            sync1;
    reg  [5:0]            sync2;
    reg  [5:0]            sync3;
    reg  [3:0]            boot_cnt;
    reg                   boot_done;
    reg                   ld_start;
    reg  [4:0]            slv_state;
    reg  [3:0]            bitcnt;
    reg  [1:0]            byte_idx;
    reg                   rw;
    reg  [7:0]            ptr;
    reg  [7:0]            shreg;
    reg  [7:0]            txsh;
    reg                   slv_oe_n;
    reg                   slv_out;
    reg                   slv_we;
    reg  [7:0]            slv_wa;
    reg  [7:0]            slv_wd;
    wire                  ld_scl_oe_n;
    wire                  ld_sda_oe_n;
    wire                  ld_busy;
    wire                  ld_done;
    wire                  ld_error;
    wire                  ld_we;
    wire [`DPCP_RA_W-1:0] ld_wa;
    wire [7:0]            ld_wd;
    integer               i;

    // settled copies of the pins
    wire spi    = sync2[`DPCP_P_MODE];
    wire sda    = sync2[`DPCP_P_SDA];
    wire din    = sync2[`DPCP_P_DIN];
    wire sel    = sync2[`DPCP_P_SEL];
    wire wp_n   = sync2[`DPCP_P_WP];
    wire c_rise = sync2[`DPCP_P_SCL] & ~sync3[`DPCP_P_SCL];
    wire c_fall = ~sync2[`DPCP_P_SCL] & sync3[`DPCP_P_SCL];
    wire c_high = sync2[`DPCP_P_SCL] & sync3[`DPCP_P_SCL];
    wire i_start = c_high & sync3[`DPCP_P_SDA] & ~sda;
    wire i_stop  = c_high & ~sync3[`DPCP_P_SDA] & sda;
    wire [7:0] rx_byte = {shreg[6:0], din};
    wire [7:0] rd_byte = (ptr[7:`DPCP_RA_W] == 4'h0) ? regs[ptr[`DPCP_RA_W-1:0]] : 8'h00;
    wire slv_run = boot_done & ~ld_busy;

    // a port write lands only on a mapped register the protect pin allows
    function wr_allowed;
        input [7:0] a;
        input       wpn;
        begin
            wr_allowed = (a[7:`DPCP_RA_W] == 4'h0) &&
                         (wpn || (a[`DPCP_RA_W-1:0] >= `DPCP_IRQ_FIRST));
        end
    endfunction

    // two flip-flop synchronisers plus an edge history stage
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
            sync3 <= 6'h00;
        end
        else
        begin
            sync1 <= {write_protect_n, port_protocol_select, shared_sel_pin,
                      shared_din_pin, serial_clock_line_in, twowire_data_line_in};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // boot: wait for the pins to settle, then load only in two-wire mode
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            boot_cnt  <= 4'h0;
            boot_done <= 1'b0;
            ld_start  <= 1'b0;
        end
        else
        begin
            ld_start <= 1'b0;
            if (!boot_done)
            begin
                boot_cnt <= boot_cnt + 1'b1;
                if (boot_cnt == `DPCP_BOOT_WAIT)
                begin
                    boot_done <= 1'b1;
                    ld_start  <= ~spi;
                end
            end
        end
    end

    dpcp_eeprom_loader u_loader (
        .clk      (clk),
        .rstn     (rstn),
        .start    (ld_start),
        .sda_in   (sda),
        .scl_oe_n (ld_scl_oe_n),
        .sda_oe_n (ld_sda_oe_n),
        .busy     (ld_busy),
        .done     (ld_done),
        .error    (ld_error),
        .wr_en    (ld_we),
        .wr_addr  (ld_wa),
        .wr_data  (ld_wd)
    );

    // serial slave for both protocols; mode is assumed static
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            slv_state <= SL_IDLE;
            bitcnt    <= 4'h0;
            byte_idx  <= 2'h0;
            rw        <= 1'b0;
            ptr       <= 8'h00;
            shreg     <= 8'h00;
            txsh      <= 8'h00;
            slv_oe_n  <= 1'b1;
            slv_out   <= 1'b0;
            slv_we    <= 1'b0;
            slv_wa    <= 8'h00;
            slv_wd    <= 8'h00;
        end
        else
        begin
            slv_we <= 1'b0;
            if (!slv_run)
            begin
                slv_state <= SL_IDLE;
                slv_oe_n  <= 1'b1;
            end
            else if (spi)
            begin
                slv_oe_n <= sel;
                if (sel)
                begin
                    bitcnt   <= 4'h0;
                    byte_idx <= 2'h0;
                end
                else if (c_rise)
                begin
                    shreg  <= rx_byte;
                    bitcnt <= bitcnt + 1'b1;
                    if (bitcnt == 4'h7)
                    begin
                        bitcnt <= 4'h0;
                        if (byte_idx == 2'h0)
                        begin
                            byte_idx <= 2'h1;
                            rw       <= rx_byte[7];
                            ptr      <= {1'b0, rx_byte[6:0]};
                        end
                        else if (!rw)
                        begin
                            slv_we <= wr_allowed(ptr, wp_n);
                            slv_wa <= ptr;
                            slv_wd <= rx_byte;
                            ptr    <= ptr + 1'b1;
                        end
                    end
                end
                else if (c_fall && rw && byte_idx != 2'h0)
                begin
                    if (bitcnt == 4'h0)
                    begin
                        slv_out <= rd_byte[7];
                        txsh    <= {rd_byte[6:0], 1'b0};
                        ptr     <= ptr + 1'b1;
                    end
                    else
                    begin
                        slv_out <= txsh[7];
                        txsh    <= {txsh[6:0], 1'b0};
                    end
                end
            end
            else if (i_start)
            begin
                slv_state <= SL_RX;
                bitcnt    <= 4'h0;
                byte_idx  <= 2'h0;
                slv_oe_n  <= 1'b1;
                slv_out   <= 1'b0;
            end
            else if (i_stop)
            begin
                slv_state <= SL_IDLE;
                slv_oe_n  <= 1'b1;
            end
            else
            begin
                case (slv_state)
                    SL_RX:
                        if (c_rise)
                        begin
                            shreg  <= {shreg[6:0], sda};
                            bitcnt <= bitcnt + 1'b1;
                        end
                        else if (c_fall && bitcnt == 4'h8)
                        begin
                            bitcnt    <= 4'h0;
                            slv_state <= SL_ACK;
                            slv_oe_n  <= 1'b0;
                            if (byte_idx == 2'h0)
                            begin
                                rw <= shreg[0];
                                if (shreg[7:1] != {`DPCP_SLV_BASE, din, sel})
                                begin
                                    slv_state <= SL_IDLE;
                                    slv_oe_n  <= 1'b1;
                                end
                            end
                            else if (byte_idx == 2'h1)
                                ptr <= shreg;
                            else
                            begin
                                slv_we <= wr_allowed(ptr, wp_n);
                                slv_wa <= ptr;
                                slv_wd <= shreg;
                                ptr    <= ptr + 1'b1;
                            end
                        end
                    SL_ACK, SL_MACK:
                        if (c_rise && slv_state == SL_MACK && sda)
                            slv_state <= SL_IDLE;           // master ended the read
                        else if (c_fall && rw && byte_idx == 2'h0 || c_fall && slv_state == SL_MACK)
                        begin
                            slv_state <= SL_TX;
                            slv_oe_n  <= rd_byte[7];
                            shreg     <= rd_byte;
                            ptr       <= ptr + 1'b1;
                            bitcnt    <= 4'h1;
                            byte_idx  <= 2'h1;
                        end
                        else if (c_fall)
                        begin
                            slv_state <= SL_RX;
                            slv_oe_n  <= 1'b1;
                            byte_idx  <= (byte_idx == 2'h0) ? 2'h1 : 2'h2;
                        end
                    SL_TX:
                        if (c_fall)
                        begin
                            if (bitcnt == 4'h8)
                            begin
                                slv_state <= SL_MACK;
                                slv_oe_n  <= 1'b1;
                            end
                            else
                            begin
                                slv_oe_n <= shreg[6];
                                shreg    <= {shreg[6:0], 1'b0};
                                bitcnt   <= bitcnt + 1'b1;
                            end
                        end
                    default:
                        slv_oe_n <= 1'b1;
                endcase
            end
        end
    end

    // register file; eeprom load has priority over the port
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (i = 0; i < `DPCP_NREG; i = i + 1)
                regs[i] <= `DPCP_REG_RST;
        end
        else if (ld_we)
            regs[ld_wa] <= ld_wd;
        else if (slv_we)
            regs[slv_wa[`DPCP_RA_W-1:0]] <= slv_wd;
    end

    // registered pin drive and status
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            serial_clock_line_out  <= 1'b0;
            serial_clock_line_oe_n <= 1'b1;
            twowire_data_line_out  <= 1'b0;
            twowire_data_line_oe_n <= 1'b1;
            cfg_rd_data            <= `DPCP_REG_RST;
            spi_mode_active        <= 1'b0;
            load_busy              <= 1'b0;
            load_done              <= 1'b0;
            load_error             <= 1'b0;
        end
        else
        begin
            serial_clock_line_out  <= 1'b0;
            serial_clock_line_oe_n <= spi | ld_scl_oe_n;
            twowire_data_line_out  <= spi & slv_out;
            twowire_data_line_oe_n <= ld_busy ? ld_sda_oe_n : slv_oe_n;
            cfg_rd_data            <= regs[cfg_rd_addr];
            spi_mode_active        <= spi;
            load_busy              <= ld_busy;
            load_done              <= ld_done;
            load_error             <= ld_error;
        end
    end
endmodule

// *** sim/dpcp_port_checker_assertions.sv ***
// assertion checker watching the configuration port pins
`timescale 1ns/1ns
module dpcp_port_checker (
    input wire clk,
    input wire rstn,
    input wire port_protocol_select,
    input wire shared_sel_pin,
    input wire serial_clock_line_out,
    input wire serial_clock_line_oe_n,
    input wire twowire_data_line_out,
    input wire twowire_data_line_oe_n,
    input wire spi_mode_active,
    input wire load_busy,
    input wire load_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // chip select held low or high in four-wire mode for five samples
    sequence s_sel_low;
        (spi_mode_active && !shared_sel_pin)[*5];
    endsequence
    sequence s_sel_high;
        (spi_mode_active && shared_sel_pin)[*5];
    endsequence
    chk_mode_follows_pin: assert property (($stable(port_protocol_select))[*5] |-> spi_mode_active == port_protocol_select)
        else $error("mode output does not follow select pin");
    chk_sel_drives_data: assert property (s_sel_low |-> !twowire_data_line_oe_n)
        else $error("data pin not driven while selected");
    chk_unsel_releases: assert property (s_sel_high |-> twowire_data_line_oe_n)
        else $error("data pin driven while not selected");
    chk_sda_open_drain: assert property (!spi_mode_active && !twowire_data_line_oe_n |-> !twowire_data_line_out)
        else $error("two-wire data driven high");
    chk_spi_clock_input: assert property (spi_mode_active |-> serial_clock_line_oe_n)
        else $error("clock pin driven in four-wire mode");
    chk_scl_open_drain: assert property (!serial_clock_line_oe_n |-> !serial_clock_line_out)
        else $error("clock pin driven high");
    chk_spi_no_load: assert property (spi_mode_active |-> !load_busy)
        else $error("eeprom load in four-wire mode");
    chk_load_end_done: assert property ($fell(load_busy) |-> load_done ##1 load_done)
        else $error("load finished without done");
endmodule
bind dpcp_config_port dpcp_port_checker u_chk (.clk, .rstn, .port_protocol_select, .shared_sel_pin,
    .serial_clock_line_out, .serial_clock_line_oe_n, .twowire_data_line_out, .twowire_data_line_oe_n,
    .spi_mode_active, .load_busy, .load_done);

// *** sim/dpcp_eeprom_model.sv ***
// two-wire eeprom model answering the boot loader
`timescale 1ns/1ns
module dpcp_eeprom_model (
    input wire scl,
    input wire sda,
    output reg sda_oe_n
);
    reg [7:0] sr;
    reg [7:0] idx;
    reg       rd;
    integer   cnt;
    initial
    begin
        sda_oe_n = 1'b1;
        cnt = 0;
        idx = 8'h00;
        rd = 1'b0;
    end
    // start condition restarts byte framing
    always @(negedge sda)
        if (scl === 1'b1)
        begin
            cnt = 0;
            idx = 8'h00;
            rd = 1'b0;
            sda_oe_n = 1'b1;
        end
    // bits are taken on the clock rise
    always @(posedge scl)
        sr = {sr[6:0], sda};
    // a master nack ends the read
    always @(posedge scl)
        if (cnt == 9 && rd && sda)
            rd = 1'b0;
    // after each fall: ack written bytes, shift out read bytes 0x30 upward
    always @(negedge scl)
    begin
        if (cnt == 8 && idx == 8'h00)
            rd = sr[0];
        if (cnt == 9)
        begin
            idx = idx + 8'h01;
            cnt = 1;
        end
        else
            cnt = cnt + 1;
        if (rd && idx != 8'h00)
            sda_oe_n = (cnt == 9) | (8'h2f + idx) >> (8 - cnt);
        else
            sda_oe_n = (cnt != 9);
    end
endmodule

// *** sim/test_dual_protocol_config_port.sv ***
// self-checking bench for the dual protocol configuration port
`timescale 1ns/1ns
`include "dpcp_defs.vh"
`define CHK(g, e) begin n_tests = n_tests + 1; if ((g) !== (e)) begin mismatches = mismatches + 1; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_dual_protocol_config_port;
    reg        clk, rstn, mode, sel, din, wpn, sclk, hd;
    reg  [3:0] ra;
    wire [7:0] rd_data;
    wire       scl_out, scl_oe_n, sda_out, sda_oe_n, spi_on, busy, done, err, ee_oe_n;
    integer    mismatches, n_tests, i;
    reg  [7:0] rv;
    // open-drain lines with pull-ups; the host owns the clock in four-wire mode
    wire scl_line = mode ? sclk : (scl_oe_n | scl_out) & sclk;
    wire sda_line = (sda_oe_n ? 1'b1 : sda_out) & (mode | ee_oe_n & hd);
    dpcp_config_port dut (.clk(clk), .rstn(rstn), .port_protocol_select(mode), .shared_sel_pin(sel),
        .shared_din_pin(din), .write_protect_n(wpn), .serial_clock_line_in(scl_line),
        .serial_clock_line_out(scl_out), .serial_clock_line_oe_n(scl_oe_n), .twowire_data_line_in(sda_line),
        .twowire_data_line_out(sda_out), .twowire_data_line_oe_n(sda_oe_n), .cfg_rd_addr(ra),
        .cfg_rd_data(rd_data), .spi_mode_active(spi_on), .load_busy(busy), .load_done(done), .load_error(err));
    dpcp_eeprom_model ee (.scl(mode ? 1'b0 : scl_line), .sda(sda_line), .sda_oe_n(ee_oe_n));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task give_verdict;
    begin
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    // internal register read, data one cycle after the address
    task rd_reg(input [3:0] a, output [7:0] d);
    begin
        @(negedge clk) ra = a;
        repeat (2) @(negedge clk);
        d = rd_data;
    end
    endtask
    // one four-wire frame of command and data byte, 400 ns link clock
    task fw(input [15:0] w, output [7:0] r);
        integer k;
    begin
        @(negedge clk) sel = 1'b0;
        repeat (4) @(negedge clk);
        for (k = 15; k >= 0; k = k - 1)
        begin
            din = w[k];
            repeat (4) @(negedge clk);
            sclk = 1'b1;
            r = {r[6:0], sda_line};
            repeat (4) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (4) @(negedge clk);
        sel = 1'b1;
        din = ~din;
        repeat (8) @(negedge clk);
    end
    endtask
    // two-wire boot copies the eeprom image into all registers
    task t_boot_load;
    begin
        for (i = 0; i < 60000 && done !== 1'b1; i = i + 1)
            @(negedge clk);
        `CHK(done, 1'b1)
        if (done !== 1'b1)
            give_verdict;
        `CHK(err, 1'b0)
        `CHK(spi_on, 1'b0)
        for (i = 0; i < 16; i = i + 1)
        begin
            rd_reg(i[3:0], rv);
            `CHK(rv, 8'h30 + i[7:0])
        end
        $display("boot load test done");
    end
    endtask
    // two-wire host writes register 0xd; slave acks each byte
    task t_twowire;
        reg [26:0] f;
        integer k;
    begin
        f = {8'h64, 1'b1, 8'h0d, 1'b1, 8'h96, 1'b1};
        @(negedge clk) hd = 1'b0;
        repeat (4) @(negedge clk);
        for (k = 26; k >= 0; k = k - 1)
        begin
            sclk = 1'b0;
            hd = f[k];
            repeat (4) @(negedge clk);
            sclk = 1'b1;
            if (k % 9 == 0)
                `CHK(sda_oe_n, 1'b0)
            repeat (4) @(negedge clk);
        end
        sclk = 1'b0;
        hd = 1'b0;
        repeat (4) @(negedge clk);
        sclk = 1'b1;
        repeat (4) @(negedge clk);
        hd = 1'b1;
        rd_reg(4'hd, rv);
        `CHK(rv, 8'h96)
        $display("two-wire write test done");
    end
    endtask
    // reset into four-wire mode: defaults back, no eeprom load
    task t_spi_mode;
    begin
        @(negedge clk) rstn = 1'b0;
        mode = 1'b1;
        sclk = 1'b0;
        sel = 1'b1;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        rv = 8'h00;
        for (i = 0; i < 3000; i = i + 1)
        begin
            @(negedge clk);
            rv = rv | {7'h00, busy};
        end
        `CHK(rv, 8'h00)
        `CHK(done, 1'b0)
        `CHK(spi_on, 1'b1)
        `CHK(scl_oe_n, 1'b1)
        `CHK(sda_oe_n, 1'b1)
        rd_reg(4'h0, rv);
        `CHK(rv, 8'h00)
        $display("four-wire mode test done");
    end
    endtask
    // protected and open writes, then read back through the pins
    task t_spi_regs;
    begin
        wpn = 1'b0;
        fw({8'h02, 8'h5a}, rv);
        fw({8'h0c, 8'ha5}, rv);
        wpn = 1'b1;
        fw({8'h03, 8'h3c}, rv);
        rd_reg(4'h2, rv);
        `CHK(rv, 8'h00)
        rd_reg(4'hc, rv);
        `CHK(rv, 8'ha5)
        rd_reg(4'h3, rv);
        `CHK(rv, 8'h3c)
        fw({8'h8c, 8'h00}, rv);
        `CHK(rv, 8'ha5)
        fw({8'h83, 8'hff}, rv);
        `CHK(rv, 8'h3c)
        $display("four-wire register test done");
    end
    endtask
    initial
    begin
        mismatches = 0;
        n_tests = 0;
        rstn = 1'b0;
        mode = 1'b0;
        sel = 1'b0;
        din = 1'b1;
        wpn = 1'b1;
        sclk = 1'b1;
        hd = 1'b1;
        ra = 4'h0;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        t_boot_load;
        t_twowire;
        t_spi_mode;
        t_spi_regs;
        give_verdict;
    end
endmodule
